/* rtl/dcs_dma_channels.sv */
// DMA channel address, count and status registers with an AHB-Lite slave and a transfer buffer
`timescale 1ns/1ps
module dcs_dma_channels (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Peripheral data stream
    input wire logic in_valid,
    input wire logic [dcs_pkg::CH_W-1:0] in_chan,
    input wire logic [dcs_pkg::PAD_W-1:0] in_data,
    output logic in_ready,
    // Toward DMA RAM
    output logic out_valid,
    input wire logic out_ready,
    output dcs_pkg::dcs_xfer_t out_xfer
);

    dcs_pkg::dcs_state_t s_q;
    dcs_pkg::dcs_state_t s_d;
    dcs_pkg::dcs_xfer_t push_xfer;
    logic fifo_ready;
    logic push;
    logic addr_phase;
    logic [dcs_pkg::NUM_CH-1:0] pp_flags;

    // Zero-wait-state slave, every answer is OKAY
    assign hreadyout = 1'b1;
    assign hresp = dcs_pkg::HRESP_OKAY;
    assign hrdata = s_q.rdata;

    assign addr_phase = hsel && (htrans == dcs_pkg::HTRANS_NONSEQ) && hready;

    // Only enabled channels may hand data over; a full buffer stalls the source
    assign in_ready = fifo_ready && s_q.ch[in_chan].en;
    assign push = in_valid && in_ready;

    // Transfer record carries the programmed peripheral address of its channel
    always_comb
    begin
        push_xfer.chan = in_chan;
        push_xfer.addr = s_q.ch[in_chan].pad;
        push_xfer.data = in_data;
    end

    // Ping-pong flags gathered for the status word
    for (genvar g = 0; g < dcs_pkg::NUM_CH; g++)
    begin : g_pp
        assign pp_flags[g] = s_q.ch[g].pp_flag;
    end

    // Register read mux; unmapped and reserved locations read as zero
    function automatic logic [31:0] read_word(input dcs_pkg::dcs_state_t s, input logic [31:0] a,
                                              input logic [dcs_pkg::NUM_CH-1:0] pp);
        logic [31:0] w;
        logic [dcs_pkg::CH_W-1:0] idx;
        w = 32'h0000_0000;
        idx = a[dcs_pkg::SLOT_MSB:dcs_pkg::SLOT_LSB];
        if (a[31:dcs_pkg::MAP_MSB+1] != '0)
        begin
            w = 32'h0000_0000;
        end
        else if (a[dcs_pkg::MAP_MSB:0] == dcs_pkg::STATUS_ADDR)
        begin
            w[dcs_pkg::STAT_LAST_LSB +: dcs_pkg::LAST_W] = s.last_ch;
            w[dcs_pkg::STAT_PP_LSB +: dcs_pkg::NUM_CH] = pp;
        end
        else if (a[dcs_pkg::MAP_MSB] || a[1:0] != 2'h0)
        begin
            w = 32'h0000_0000;
        end
        else if (a[dcs_pkg::REG_MSB:dcs_pkg::REG_LSB] == dcs_pkg::REG_PAD)
        begin
            w[dcs_pkg::PAD_W-1:0] = s.ch[idx].pad;
        end
        else if (a[dcs_pkg::REG_MSB:dcs_pkg::REG_LSB] == dcs_pkg::REG_CNT)
        begin
            w[dcs_pkg::CNT_W-1:0] = s.ch[idx].cnt;
        end
        else if (a[dcs_pkg::REG_MSB:dcs_pkg::REG_LSB] == dcs_pkg::REG_CTRL)
        begin
            w[dcs_pkg::CTRL_EN_BIT] = s.ch[idx].en;
            w[dcs_pkg::CTRL_PPM_BIT] = s.ch[idx].ppm;
        end
        return w;
    endfunction

    // Next-state logic: bus write, then transfer bookkeeping, then read capture
    always_comb
    begin
        logic [dcs_pkg::CH_W-1:0] widx;
        logic [dcs_pkg::CH_W-1:0] c;
        s_d = s_q;
        widx = s_q.wr_addr[dcs_pkg::SLOT_MSB:dcs_pkg::SLOT_LSB];
        c = in_chan;
        s_d.wr_pend = 1'b0;

        // Write data phase; enabled channels are not protected from rewrites
        if (s_q.wr_pend)
        begin
            if (s_q.wr_addr[dcs_pkg::MAP_MSB] || s_q.wr_addr[1:0] != 2'h0)
            begin
                s_d.wr_pend = 1'b0;
            end
            else if (s_q.wr_addr[dcs_pkg::REG_MSB:dcs_pkg::REG_LSB] == dcs_pkg::REG_PAD)
            begin
                s_d.ch[widx].pad = hwdata[dcs_pkg::PAD_W-1:0];
            end
            else if (s_q.wr_addr[dcs_pkg::REG_MSB:dcs_pkg::REG_LSB] == dcs_pkg::REG_CNT)
            begin
                s_d.ch[widx].cnt = hwdata[dcs_pkg::CNT_W-1:0];
            end
            else if (s_q.wr_addr[dcs_pkg::REG_MSB:dcs_pkg::REG_LSB] == dcs_pkg::REG_CTRL)
            begin
                // Enabling arms a fresh run of count plus one transfers
                if (hwdata[dcs_pkg::CTRL_EN_BIT] && !s_q.ch[widx].en)
                begin
                    s_d.ch[widx].remain = s_q.ch[widx].cnt;
                    s_d.ch[widx].pp_flag = 1'b0;
                end
                s_d.ch[widx].en = hwdata[dcs_pkg::CTRL_EN_BIT];
                s_d.ch[widx].ppm = hwdata[dcs_pkg::CTRL_PPM_BIT];
            end
        end

        // A transfer handed to the buffer counts down its channel and updates status
        if (push)
        begin
            s_d.last_ch = {1'b0, c};
            if (s_d.ch[c].remain == '0)
            begin
                if (s_d.ch[c].ppm)
                begin
                    s_d.ch[c].pp_flag = !s_d.ch[c].pp_flag;
                    s_d.ch[c].remain = s_d.ch[c].cnt;
                end
                else
                begin
                    s_d.ch[c].en = 1'b0;
                end
            end
            else
            begin
                s_d.ch[c].remain = s_d.ch[c].remain - 1'b1;
            end
        end

        // Address phase: writes wait for their data, reads are answered next cycle from a flop
        if (addr_phase)
        begin
            if (hwrite)
            begin
                s_d.wr_pend = (haddr[31:dcs_pkg::MAP_MSB+1] == '0);
                s_d.wr_addr = haddr[dcs_pkg::MAP_MSB:0];
            end
            else
            begin
                s_d.rdata = read_word(s_q, haddr, pp_flags);
            end
        end
    end

    // State register; last-channel starts at all ones until a transfer happens
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_q <= '0;
            s_q.last_ch <= dcs_pkg::LAST_NONE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Eight-word buffer between the peripheral stream and DMA RAM
    dcs_fifo #(
        .WIDTH($bits(dcs_pkg::dcs_xfer_t)),
        .DEPTH(dcs_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(hclk),
        .rst_n(hresetn),
        .wr_valid(push),
        .wr_ready(fifo_ready),
        .wr_data(push_xfer),
        .rd_valid(out_valid),
        .rd_ready(out_ready),
        .rd_data(out_xfer)
    );

    // Peripheral address write keeps the low 16 bits of the word in the channel
    property p_pad_write;
        @(posedge hclk) disable iff (!hresetn)
        (s_q.wr_pend && !s_q.wr_addr[dcs_pkg::MAP_MSB] && s_q.wr_addr[1:0] == 2'h0 &&
         s_q.wr_addr[dcs_pkg::REG_MSB:dcs_pkg::REG_LSB] == dcs_pkg::REG_PAD)
        |=> (s_q.ch[$past(s_q.wr_addr[dcs_pkg::SLOT_MSB:dcs_pkg::SLOT_LSB])].pad == $past(hwdata[15:0]));
    endproperty
    a_pad_write: assert property (p_pad_write) else $error("peripheral address not stored");

    // Count register reads never show the unimplemented bits
    property p_cnt_upper_zero;
        @(posedge hclk) disable iff (!hresetn)
        (addr_phase && !hwrite && haddr[31:dcs_pkg::MAP_MSB] == '0 && haddr[1:0] == 2'h0 &&
         haddr[dcs_pkg::REG_MSB:dcs_pkg::REG_LSB] == dcs_pkg::REG_CNT)
        |=> (hrdata[31:dcs_pkg::CNT_W] == '0 &&
             hrdata[dcs_pkg::CNT_W-1:0] == $past(s_q.ch[haddr[dcs_pkg::SLOT_MSB:dcs_pkg::SLOT_LSB]].cnt));
    endproperty
    a_cnt_upper_zero: assert property (p_cnt_upper_zero) else $error("count read wrong");

    // Final transfer of a one-shot run disables the channel
    property p_last_xfer_stops;
        @(posedge hclk) disable iff (!hresetn)
        (push && !s_q.wr_pend && s_q.ch[in_chan].remain == '0 && !s_q.ch[in_chan].ppm)
        |=> !s_q.ch[$past(in_chan)].en;
    endproperty
    a_last_xfer_stops: assert property (p_last_xfer_stops) else $error("channel ran past its count");

    // Every transfer before the last of its run, with no bus write pending, keeps the channel alive and counts down by one
    property p_count_down;
        @(posedge hclk) disable iff (!hresetn)
        (push && !s_q.wr_pend && s_q.ch[in_chan].remain != '0)
        |=> s_q.ch[$past(in_chan)].en &&
            s_q.ch[$past(in_chan)].remain == $past(s_q.ch[in_chan].remain) - 1'b1;
    endproperty
    a_count_down: assert property (p_count_down) else $error("count did not step by one");

    // Status names the channel of the latest transfer
    property p_last_channel;
        @(posedge hclk) disable iff (!hresetn)
        push |=> (s_q.last_ch == {1'b0, $past(in_chan)});
    endproperty
    a_last_channel: assert property (p_last_channel) else $error("last channel not recorded");

    // Codes eight to fourteen never appear
    property p_last_range;
        @(posedge hclk) disable iff (!hresetn)
        s_q.last_ch[3] |-> (s_q.last_ch == dcs_pkg::LAST_NONE);
    endproperty
    a_last_range: assert property (p_last_range) else $error("illegal last channel code");

    // All ones hold until the first transfer
    property p_last_none_holds;
        @(posedge hclk) disable iff (!hresetn)
        (s_q.last_ch == dcs_pkg::LAST_NONE && !push) |=> (s_q.last_ch == dcs_pkg::LAST_NONE);
    endproperty
    a_last_none_holds: assert property (p_last_none_holds) else $error("last channel left reset value");

    // Ping-pong run end swaps the buffer flag
    property p_pingpong_swap;
        @(posedge hclk) disable iff (!hresetn)
        (push && !s_q.wr_pend && s_q.ch[in_chan].remain == '0 && s_q.ch[in_chan].ppm)
        |=> (s_q.ch[$past(in_chan)].pp_flag != $past(s_q.ch[in_chan].pp_flag));
    endproperty
    a_pingpong_swap: assert property (p_pingpong_swap) else $error("ping-pong flag did not swap");

    // Peripheral address reads return the value held at the address edge, zeros above
    property p_pad_read;
        @(posedge hclk) disable iff (!hresetn)
        (addr_phase && !hwrite && haddr[31:dcs_pkg::MAP_MSB] == '0 && haddr[1:0] == 2'h0 &&
         haddr[dcs_pkg::REG_MSB:dcs_pkg::REG_LSB] == dcs_pkg::REG_PAD)
        |=> (hrdata == {16'h0000, $past(s_q.ch[haddr[dcs_pkg::SLOT_MSB:dcs_pkg::SLOT_LSB]].pad)});
    endproperty
    a_pad_read: assert property (p_pad_read) else $error("peripheral address read wrong");

    // Count write keeps only the implemented low bits
    property p_cnt_write;
        @(posedge hclk) disable iff (!hresetn)
        (s_q.wr_pend && !s_q.wr_addr[dcs_pkg::MAP_MSB] && s_q.wr_addr[1:0] == 2'h0 &&
         s_q.wr_addr[dcs_pkg::REG_MSB:dcs_pkg::REG_LSB] == dcs_pkg::REG_CNT)
        |=> (s_q.ch[$past(s_q.wr_addr[dcs_pkg::SLOT_MSB:dcs_pkg::SLOT_LSB])].cnt ==
             $past(hwdata[dcs_pkg::CNT_W-1:0]));
    endproperty
    a_cnt_write: assert property (p_cnt_write) else $error("count not stored");

    // Status read shows the last channel and the flags; unused upper bits stay zero
    property p_status_read;
        @(posedge hclk) disable iff (!hresetn)
        (addr_phase && !hwrite && haddr == {24'h000000, dcs_pkg::STATUS_ADDR})
        |=> (hrdata[31:dcs_pkg::STAT_LAST_LSB+dcs_pkg::LAST_W] == '0 &&
             hrdata[dcs_pkg::STAT_LAST_LSB +: dcs_pkg::LAST_W] == $past(s_q.last_ch) &&
             hrdata[dcs_pkg::STAT_PP_LSB +: dcs_pkg::NUM_CH] == $past(pp_flags));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    // Enabling an idle channel arms a full run and selects buffer A
    property p_arm_on_enable;
        @(posedge hclk) disable iff (!hresetn)
        (s_q.wr_pend && !s_q.wr_addr[dcs_pkg::MAP_MSB] && s_q.wr_addr[1:0] == 2'h0 &&
         s_q.wr_addr[dcs_pkg::REG_MSB:dcs_pkg::REG_LSB] == dcs_pkg::REG_CTRL &&
         hwdata[dcs_pkg::CTRL_EN_BIT] &&
         !s_q.ch[s_q.wr_addr[dcs_pkg::SLOT_MSB:dcs_pkg::SLOT_LSB]].en)
        |=> (s_q.ch[$past(s_q.wr_addr[dcs_pkg::SLOT_MSB:dcs_pkg::SLOT_LSB])].remain ==
             $past(s_q.ch[s_q.wr_addr[dcs_pkg::SLOT_MSB:dcs_pkg::SLOT_LSB]].cnt) &&
             !s_q.ch[$past(s_q.wr_addr[dcs_pkg::SLOT_MSB:dcs_pkg::SLOT_LSB])].pp_flag);
    endproperty
    a_arm_on_enable: assert property (p_arm_on_enable) else $error("enable did not arm the run");

endmodule

/* rtl/dcs_pkg.sv */
// Package: register map, field layout, reset values and carrier types of the DMA channel slice
package dcs_pkg;

    // Channel count and field widths
    localparam int NUM_CH = 8;
    localparam int CH_W = 3;
    localparam int PAD_W = 16;
    localparam int CNT_W = 10;
    localparam int LAST_W = 4;
    localparam int FIFO_DEPTH = 8;

    // Byte map: channel n occupies a 16-byte slot at n * 0x10, status sits above all slots
    localparam logic [7:0] STATUS_ADDR = 8'h80;
    localparam logic [1:0] REG_PAD = 2'h0;
    localparam logic [1:0] REG_CNT = 2'h1;
    localparam logic [1:0] REG_CTRL = 2'h2;
    localparam int SLOT_LSB = 4;
    localparam int SLOT_MSB = 6;
    localparam int REG_LSB = 2;
    localparam int REG_MSB = 3;
    localparam int MAP_MSB = 7;

    // Control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_PPM_BIT = 1;

    // Status register fields
    localparam int STAT_PP_LSB = 0;
    localparam int STAT_LAST_LSB = 8;

    // Reset values
    localparam logic [PAD_W-1:0] PAD_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
    localparam logic [LAST_W-1:0] LAST_NONE = 4'hF;

    // AHB transfer types and response
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // One transfer moving through the buffer toward DMA RAM
    typedef struct packed {
        logic [CH_W-1:0] chan;
        logic [PAD_W-1:0] addr;
        logic [PAD_W-1:0] data;
    } dcs_xfer_t;

    // Per-channel programming and progress
    typedef struct packed {
        logic [PAD_W-1:0] pad;
        logic [CNT_W-1:0] cnt;
        logic en;
        logic ppm;
        logic [CNT_W-1:0] remain;
        logic pp_flag;
    } dcs_chan_t;

    // Whole state of the channel block
    typedef struct packed {
        dcs_chan_t [NUM_CH-1:0] ch;
        logic [LAST_W-1:0] last_ch;
        logic wr_pend;
        logic [MAP_MSB:0] wr_addr;
        logic [31:0] rdata;
    } dcs_state_t;

endpackage

/* rtl/dcs_fifo.sv */
// Synchronous valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
module dcs_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    // Drain side
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } dcs_fifo_state_t;

    dcs_fifo_state_t s_q;
    dcs_fifo_state_t s_d;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count
    assign wr_ready = (s_q.cnt != DEPTH[AW:0]);
    assign rd_valid = (s_q.cnt != '0);
    assign rd_data = s_q.mem[s_q.rp];
    assign push = wr_valid && wr_ready;
    assign pop = rd_valid && rd_ready;

    // Pointer wrap relies on DEPTH being a power of two
    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wp] = wr_data;
            s_d.wp = s_q.wp + 1'b1;
        end
        if (pop)
        begin
            s_d.rp = s_q.rp + 1'b1;
        end
        if (push && !pop)
        begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
        else if (pop && !push)
        begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule

/* bench/dcs_periph_model.sv */
// Peripheral source and DMA RAM sink facing the DMA channel slice
`timescale 1ns/1ps
module dcs_periph_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bench control
    input wire logic send,
    input wire logic [dcs_pkg::CH_W-1:0] chan,
    input wire logic stall,
    // Words offered to the block
    output logic in_valid,
    output logic [dcs_pkg::CH_W-1:0] in_chan,
    output logic [dcs_pkg::PAD_W-1:0] in_data,
    input wire logic in_ready,
    // Records leaving toward DMA RAM
    input wire logic out_valid,
    output logic out_ready,
    input wire dcs_pkg::dcs_xfer_t out_xfer,
    // Tallies for the bench
    output int pushed,
    output int popped,
    output dcs_pkg::dcs_xfer_t last_pop
);
    // Hold a word until taken; once withdrawn the data lines scramble so stale data never looks valid
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            in_valid <= 1'h0;
            in_chan <= 3'h0;
            in_data <= 16'h0000;
            pushed <= 0;
        end
        else
        begin
            if (in_valid && in_ready)
                pushed <= pushed + 1;
            if (!send)
            begin
                in_valid <= 1'h0;
                in_data <= ~in_data;
            end
            else if (!in_valid || in_ready)
            begin
                in_valid <= 1'h1;
                in_chan <= chan;
                in_data <= 16'($urandom);
            end
        end
    end

    // RAM side accepts at random moments, never from the cycle after stall is sampled high
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            out_ready <= 1'h0;
            popped <= 0;
            last_pop <= '0;
        end
        else
        begin
            out_ready <= !stall && ($urandom_range(3) != 0);
            if (out_valid && out_ready)
            begin
                popped <= popped + 1;
                last_pop <= out_xfer;
            end
        end
    end
endmodule

/* bench/tb_dma_channel_addr_count_status.sv */
// Testbench of the DMA channel slice: registers, transfer runs, ping-pong and buffer fill
`timescale 1ns/1ps
module tb_dma_channel_addr_count_status;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h00000000;
    logic hreadyout, hresp, in_valid, in_ready, out_valid, out_ready;
    logic [31:0] hrdata, rd, v;
    logic send = 1'h0;
    logic stall = 1'h0;
    logic [2:0] chan = 3'h0;
    logic [2:0] in_chan;
    logic [15:0] in_data;
    logic [15:0] pads [8];
    logic [15:0] last_in;
    logic [9:0] cnt;
    dcs_pkg::dcs_xfer_t out_xfer, last_pop;
    int pushed, popped, base, n;
    int fails = 0;
    int num_checks = 0;

    // Clock at 20 MHz
    always #25 hclk = ~hclk;

    dcs_dma_channels dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .in_valid(in_valid), .in_chan(in_chan), .in_data(in_data),
        .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready), .out_xfer(out_xfer));

    dcs_periph_model peer_u (.hclk(hclk), .hresetn(hresetn), .send(send), .chan(chan), .stall(stall),
        .in_valid(in_valid), .in_chan(in_chan), .in_data(in_data), .in_ready(in_ready),
        .out_valid(out_valid), .out_ready(out_ready), .out_xfer(out_xfer), .pushed(pushed),
        .popped(popped), .last_pop(last_pop));

    // Latest word the block accepted; the buffer must hand it out last
    always @(posedge hclk)
        if (in_valid && in_ready)
            last_in <= in_data;

    // Verdict and end of run
    task automatic conclude();
        if (fails == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded waits; running out counts as a mismatch
    task automatic wait_for(input logic pops, input int target);
        for (int i = 0; i < 400 && (pops ? popped : pushed) < target; i++)
            @(posedge hclk);
        if ((pops ? popped : pushed) < target)
        begin
            fails++;
            conclude();
        end
    endtask

    task automatic ready_edge();
        @(posedge hclk);
        for (int i = 0; hreadyout !== 1'h1 && i < 50; i++)
            @(posedge hclk);
        if (hreadyout !== 1'h1)
        begin
            fails++;
            conclude();
        end
    endtask

    // One single-word AHB-Lite transfer; read data lands in rd
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= dcs_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        ready_edge();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        ready_edge();
        rd = hrdata;
        check({31'h00000000, hresp}, {31'h00000000, dcs_pkg::HRESP_OKAY});
    endtask

    function automatic logic [31:0] ra(input int c, input logic [1:0] r);
        return 32'(c * 16) + 32'({r, 2'h0});
    endfunction

    function automatic logic [31:0] stat_exp(input logic [3:0] last, input logic [7:0] pp);
        return {20'h00000, last, pp};
    endfunction

    // Program a channel while it is idle, then let the source offer words
    task automatic start(input int c, input logic [9:0] k, input logic [31:0] ctrl);
        ahb(1'h1, ra(c, dcs_pkg::REG_CNT), {22'h000000, k});
        ahb(1'h1, ra(c, dcs_pkg::REG_CTRL), ctrl);
        chan <= 3'(c);
        base = pushed;
        send <= 1'h1;
    endtask

    task automatic stop();
        send <= 1'h0;
        repeat (3) @(posedge hclk);
        wait_for(1'h1, pushed);
    endtask

    initial
    begin
        void'($urandom(32'h000009CB));
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        // Reset values, random read-back and a reserved register per channel
        for (int c = 0; c < 8; c++)
        begin
            ahb(1'h0, ra(c, dcs_pkg::REG_PAD), 32'h00000000);
            check(rd, 32'h00000000);
            ahb(1'h0, ra(c, dcs_pkg::REG_CNT), 32'h00000000);
            check(rd, 32'h00000000);
            v = $urandom;
            pads[c] = v[15:0];
            ahb(1'h1, ra(c, dcs_pkg::REG_PAD), v);
            ahb(1'h0, ra(c, dcs_pkg::REG_PAD), 32'h00000000);
            check(rd, {16'h0000, pads[c]});
            v = $urandom;
            ahb(1'h1, ra(c, dcs_pkg::REG_CNT), v);
            ahb(1'h0, ra(c, dcs_pkg::REG_CNT), 32'h00000000);
            check(rd, {22'h000000, v[9:0]});
            ahb(1'h1, ra(c, 2'h3), v);
            ahb(1'h0, ra(c, 2'h3), 32'h00000000);
            check(rd, 32'h00000000);
        end
        // Writes to the read-only status and above the map are dropped
        ahb(1'h1, {24'h000000, dcs_pkg::STATUS_ADDR}, 32'hFFFFFFFF);
        ahb(1'h0, {24'h000000, dcs_pkg::STATUS_ADDR}, 32'h00000000);
        check(rd, stat_exp(4'hF, 8'h00));
        ahb(1'h1, 32'h00000100, 32'h0000A5A5);
        ahb(1'h0, 32'h00000100, 32'h00000000);
        check(rd, 32'h00000000);
        ahb(1'h0, ra(0, dcs_pkg::REG_PAD), 32'h00000000);
        check(rd, {16'h0000, pads[0]});
        // One run per channel, a zero count among them; the channel stops by itself
        for (int c = 0; c < 8; c++)
        begin
            cnt = (c == 0) ? 10'h000 : 10'($urandom_range(4));
            start(c, cnt, 32'h00000001);
            wait_for(1'h0, base + int'(cnt) + 1);
            repeat (4) @(posedge hclk);
            check(32'(pushed - base), 32'(cnt) + 32'h00000001);
            stop();
            check({13'h0000, last_pop.chan, last_pop.addr}, {13'h0000, 3'(c), pads[c]});
            check({16'h0000, last_pop.data}, {16'h0000, last_in});
            ahb(1'h0, {24'h000000, dcs_pkg::STATUS_ADDR}, 32'h00000000);
            check(rd, stat_exp(4'(c), 8'h00));
        end
        // Ping-pong on channel 3: buffer flag follows completed runs
        start(3, 10'h001, 32'h00000003);
        repeat (9) @(posedge hclk);
        stop();
        ahb(1'h1, ra(3, dcs_pkg::REG_CTRL), 32'h00000000);
        n = pushed - base;
        ahb(1'h0, {24'h000000, dcs_pkg::STATUS_ADDR}, 32'h00000000);
        check(rd, stat_exp(4'h3, 8'((n / 2) % 2) << 3));
        // Fill the buffer against a stalled sink, then drain
        stall <= 1'h1;
        start(6, 10'h014, 32'h00000001);
        wait_for(1'h0, base + 8);
        repeat (6) @(posedge hclk);
        check(32'(pushed - base), 32'(dcs_pkg::FIFO_DEPTH));
        check({31'h00000000, out_valid}, 32'h00000001);
        stall <= 1'h0;
        wait_for(1'h0, base + 21);
        repeat (4) @(posedge hclk);
        check(32'(pushed - base), 32'h00000015);
        stop();
        check({31'h00000000, out_valid}, 32'h00000000);
        conclude();
    end
endmodule
